//--- src/tsc_pkg.sv
// Purpose: shared constants for the touch sense counter status block
// Assumes: AXI4-Lite register bus, 32-bit data, one word per register
// Notes:   register indices are word indices; byte address is four times the index

package tsc_pkg;

    // ****************************************************************
    // register indices and byte addresses
    // ****************************************************************
    localparam logic [9:0]  IDX_COUNT_LOW    = 10'h0a4;  // low count byte, read only
    localparam logic [9:0]  IDX_COUNT_HIGH   = 10'h0a5;  // high count byte, read only
    localparam logic [9:0]  IDX_STATUS_MASK  = 10'h0a6;  // sticky flags and masks
    localparam logic [9:0]  IDX_TIMER        = 10'h0a7;  // seven-bit timer count value
    localparam logic [9:0]  IDX_CONTROL      = 10'h0b0;  // enable, stop select, polarity

    localparam int          ADDR_W           = 12;       // byte address bits decoded

    // ****************************************************************
    // status and mask field positions
    // ****************************************************************
    localparam int          BIT_INPUT_STAT   = 7;        // input_event_status
    localparam int          BIT_CLOW_STAT    = 6;        // carry_low_status
    localparam int          BIT_CHIGH_STAT   = 5;        // carry_high_status
    localparam int          BIT_MDONE_STAT   = 4;        // measure_done_status
    localparam int          STAT_LSB         = 4;        // flags occupy 7:4
    localparam int          MASK_LSB         = 0;        // masks occupy 3:0

    // ****************************************************************
    // control register field positions
    // ****************************************************************
    localparam int          BIT_CTL_ENABLE   = 0;        // counter enable
    localparam int          BIT_CTL_STOP_SEL = 1;        // 1: stop on input edge
    localparam int          BIT_CTL_FLIP     = 3;        // input_polarity_flip
    localparam int          BIT_CTL_RUNNING  = 7;        // read only: counter running

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0]  RST_COUNT        = 8'h00;
    localparam logic [3:0]  RST_FLAGS        = 4'h0;
    localparam logic [3:0]  RST_MASKS        = 4'h0;
    localparam logic [6:0]  RST_TIMER        = 7'h00;
    localparam logic [7:0]  RST_CONTROL      = 8'h00;

    // ****************************************************************
    // bus response codes
    // ****************************************************************
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

//--- src/tsc_edge_detect.sv
// Purpose: synchronise the selected sense input, optionally flip it, find rising edges
// Assumes: sense input is asynchronous to mclk
// Notes:   edge pulse lags the pin by two clock edges

`timescale 1ns/100ps

module tsc_edge_detect
    import tsc_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // sense side
    input  wire logic sense_in,
    input  wire logic flip,
    // event out
    output logic      rise_pulse
);

    // ****************************************************************
    // two-stage synchroniser
    // ****************************************************************
    logic meta_q;    // first stage, read only by sync_q
    logic sync_q;    // second stage, safe to use
    logic prev_q;    // last polarity-corrected level

    // first stage feeds only the second stage
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= sense_in;
            sync_q <= meta_q;
        end
    end

    // polarity is applied after the synchroniser so a flip never glitches stage one
    logic level;
    assign level = sync_q ^ flip;

    // remember last level; a polarity change may itself look like an edge
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prev_q <= 1'b0;
        end
        else
        begin
            prev_q <= level;
        end
    end

    // rising edge of the corrected level
    assign rise_pulse = level & ~prev_q;

endmodule // tsc_edge_detect

//--- src/tsc_touch_sense_counter_status.sv
// Purpose: count readout, sticky event status with masks, timer value register
// Assumes: count_step is a one-cycle pulse from mclk-domain clock selection logic
// Notes:   registers reached over AXI4-Lite; one write and one read at a time
//
// What this block does
// - low count byte reads counter bits 7:0
// - high count byte reads high counter, read only
// - counter halts on configured stop event
// - disabled counter clears both count bytes
// - input rising edge sets status bit 7
// - low byte carry sets status bit 6
// - high byte carry sets status bit 5
// - measurement completion sets status bit 4
// - flags stick until zero written; reset zero
// - mask bits 3:0 gate events to interrupt
// - writing one keeps status flags unchanged
// - timer register holds seven-bit value, reset zero
// - config bit optionally inverts selected input
//
// Chosen here: the AXI4-Lite slave port.

`timescale 1ns/100ps

module tsc_touch_sense_counter_status
    import tsc_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // axi4-lite write address
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    // axi4-lite write response
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    // axi4-lite read address
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    // sensing side
    input  wire logic              sense_in,
    input  wire logic              count_step,
    // block interrupt and timer value
    output logic                   irq,
    output logic [6:0]             timer_value
);

    // ****************************************************************
    // decode helpers
    // ****************************************************************

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [9:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    // known register at this byte address
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = (a == reg_addr(IDX_COUNT_LOW))   || (a == reg_addr(IDX_COUNT_HIGH)) ||
                      (a == reg_addr(IDX_STATUS_MASK)) || (a == reg_addr(IDX_TIMER))      ||
                      (a == reg_addr(IDX_CONTROL));
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    logic [7:0]        count_low_q;     // low byte counter
    logic [7:0]        count_high_q;    // high byte counter
    logic [3:0]        flags_q;         // status 7:4 held at 3:0
    logic [3:0]        masks_q;         // interrupt masks
    logic [6:0]        timer_q;         // timer count value
    logic [7:0]        control_q;       // enable, stop select, flip
    logic              run_q;           // counter is counting
    logic              armed_q;         // run started since last enable

    // bus capture
    logic              aw_held_q;       // write address waiting
    logic [ADDR_W-1:0] aw_addr_q;
    logic              w_held_q;        // write data waiting
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    // ****************************************************************
    // event sources
    // ****************************************************************
    logic enable;        // counter enable
    logic stop_on_edge;  // measurement mode
    logic edge_ev;       // rising edge of selected input
    logic step_ok;       // counter advances this cycle
    logic low_carry;     // low byte wraps
    logic high_carry;    // high byte wraps
    logic measure_done;  // edge ends a measurement
    logic stop_ev;       // configured stop event

    assign enable       = control_q[BIT_CTL_ENABLE];
    assign stop_on_edge = control_q[BIT_CTL_STOP_SEL];

    // synchroniser, polarity flip and edge finder
    tsc_edge_detect tsc_edge_detect_i
    (
        .mclk       (mclk),
        .rst        (rst),
        .sense_in   (sense_in),
        .flip       (control_q[BIT_CTL_FLIP]),
        .rise_pulse (edge_ev)
    );

    assign step_ok      = run_q & count_step;
    assign low_carry    = step_ok & (count_low_q == 8'hff);
    assign high_carry   = low_carry & (count_high_q == 8'hff);
    assign measure_done = run_q & stop_on_edge & edge_ev;
    assign stop_ev      = measure_done | (~stop_on_edge & high_carry);

    // ****************************************************************
    // write path
    // ****************************************************************
    logic do_write;   // both halves present, response slot free
    logic lane0;      // low byte lane written

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
    assign lane0         = w_strb_q[0];

    // capture address and data in either order
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            else if (do_write)
            begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            else if (do_write)
            begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write response, held until bready
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // write strobes per register; count bytes have none, writes there are dropped
    logic wr_status;
    logic wr_timer;
    logic wr_control;

    assign wr_status  = do_write & lane0 & (aw_addr_q == reg_addr(IDX_STATUS_MASK));
    assign wr_timer   = do_write & lane0 & (aw_addr_q == reg_addr(IDX_TIMER));
    assign wr_control = do_write & lane0 & (aw_addr_q == reg_addr(IDX_CONTROL));

    // ****************************************************************
    // configuration registers
    // ****************************************************************

    // control; mask writes while enabled are software's to avoid
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            control_q <= RST_CONTROL;
        end
        else if (wr_control)
        begin
            control_q <= w_data_q[7:0] & 8'h0b;  // only enable, stop select, flip
        end
    end

    // masks, written with the flags in one byte
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            masks_q <= RST_MASKS;
        end
        else if (wr_status)
        begin
            masks_q <= w_data_q[MASK_LSB+3:MASK_LSB];
        end
    end

    // timer count value, seven bits
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            timer_q <= RST_TIMER;
        end
        else if (wr_timer)
        begin
            timer_q <= w_data_q[6:0];
        end
    end

    assign timer_value = timer_q;

    // ****************************************************************
    // counter
    // ****************************************************************

    // run control: starts on enable, halts for good on the stop event
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            run_q   <= 1'b0;
            armed_q <= 1'b0;
        end
        else if (!enable)
        begin
            run_q   <= 1'b0;
            armed_q <= 1'b0;
        end
        else if (!armed_q)
        begin
            run_q   <= 1'b1;
            armed_q <= 1'b1;
        end
        else if (stop_ev)
        begin
            run_q <= 1'b0;
        end
    end

    // count bytes; frozen once stopped so reads are stable
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            count_low_q  <= RST_COUNT;
            count_high_q <= RST_COUNT;
        end
        else if (!enable)
        begin
            count_low_q  <= RST_COUNT;
            count_high_q <= RST_COUNT;
        end
        else if (step_ok)
        begin
            count_low_q <= count_low_q + 8'h01;
            if (low_carry)
            begin
                count_high_q <= count_high_q + 8'h01;
            end
        end
    end

    // ****************************************************************
    // sticky status flags
    // ****************************************************************
    logic [3:0] set_vec;   // events this cycle, bit 3 is input status
    logic [3:0] keep_vec;  // written ones keep, zeros clear

    assign set_vec  = {edge_ev, low_carry, high_carry, measure_done};
    assign keep_vec = wr_status ? w_data_q[STAT_LSB+3:STAT_LSB] : 4'hf;

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            flags_q <= RST_FLAGS;
        end
        else
        begin
            flags_q <= (flags_q & keep_vec) | set_vec;
        end
    end

    // ****************************************************************
    // interrupt
    // ****************************************************************
    assign irq = |(flags_q & masks_q);

    // ****************************************************************
    // read path
    // ****************************************************************
    logic [7:0] rd_byte;  // selected register value

    // values sampled live; stability while counting is software's concern
    always_comb
    begin
        rd_byte = 8'h00;
        case (s_axi_araddr)
            reg_addr(IDX_COUNT_LOW):   rd_byte = count_low_q;
            reg_addr(IDX_COUNT_HIGH):  rd_byte = count_high_q;
            reg_addr(IDX_STATUS_MASK): rd_byte = {flags_q, masks_q};
            reg_addr(IDX_TIMER):       rd_byte = {1'b0, timer_q};
            reg_addr(IDX_CONTROL):     rd_byte = {run_q, control_q[6:0]};
            default:                   rd_byte = 8'h00;
        endcase
    end

    assign s_axi_arready = ~rvalid_q;

    // read answer one cycle after the address is taken
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

endmodule // tsc_touch_sense_counter_status

//--- sim/tsc_sense_model.sv
// Purpose: far-side model, sense comparator level and count clock pulses
// Assumes: bench sets a level and asks for a burst of count steps
// Notes:   slow mode leaves an idle cycle between pulses

`timescale 1ns/100ps

module tsc_sense_model
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // bench commands
    input  wire logic        sense_lvl,
    input  wire logic        step_go,
    input  wire logic        slow,
    input  wire logic [16:0] step_n,
    // toward the block; step_busy back to the bench
    output logic             sense_in,
    output logic             count_step,
    output logic             step_busy
);
    logic [16:0] left_q;  // pulses still owed
    logic        ph_q;    // pacing phase for slow mode

    // ****************************************************************
    // comparator output and step pulses
    // ****************************************************************
    // one-cycle pulses only, since the counter adds one per pulse
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sense_in   <= 1'b0;
            count_step <= 1'b0;
            left_q     <= 17'h00000;
            ph_q       <= 1'b0;
        end
        else
        begin
            sense_in <= sense_lvl;
            ph_q     <= ~ph_q;
            if (step_go)
            begin
                left_q     <= step_n;
                count_step <= 1'b0;
            end
            else if (left_q != 17'h00000 && (!slow || ph_q))
            begin
                left_q     <= left_q - 17'h00001;
                count_step <= 1'b1;
            end
            else
                count_step <= 1'b0;
        end
    end

    assign step_busy = (left_q != 17'h00000) || count_step;
endmodule // tsc_sense_model

//--- sim/tsc_touch_sense_counter_status_properties.sv
// Purpose: bus timing and register behaviour seen at the block ports
// Assumes: one clock domain, reset active high
// Notes:   status read check assumes no event lands during the read

`timescale 1ns/100ps

module tsc_touch_sense_counter_status_properties
    import tsc_pkg::*;
(
    // clock and reset
    input wire logic              mclk,
    input wire logic              rst,
    // write side
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    // read side
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       s_axi_rdata,
    // outputs
    input wire logic              irq,
    input wire logic [6:0]        timer_value
);
    logic ar_stat_q;  // read in flight targets the status byte

    // ****************************************************************
    // helper logic
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ar_stat_q <= 1'b0;
        else if (s_axi_arvalid && s_axi_arready)
            ar_stat_q <= (s_axi_araddr == 12'h298);
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    property timer_wr;
        logic [6:0] v;
        (wr_taken and (s_axi_awaddr == 12'h29c && s_axi_wstrb[0]), v = s_axi_wdata[6:0]) |-> ##3 timer_value == v;
    endproperty

    AST_B_LATENCY: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("bvalid latency wrong");
    AST_B_HOLD: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped early");
    AST_W_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_R_LATENCY: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before accept");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_arready)
        else $error("upper bits or early read");
    AST_IRQ_OR: assert property (s_axi_rvalid && ar_stat_q |-> irq == |(s_axi_rdata[7:4] & s_axi_rdata[3:0]))
        else $error("irq disagrees with status");
    AST_TIMER_WR: assert property (timer_wr)
        else $error("timer not written");
    AST_RESET_VAL: assert property ($fell(rst) |-> !irq && timer_value == 7'h00)
        else $error("outputs not cleared by reset");
endmodule // tsc_touch_sense_counter_status_properties

bind tsc_touch_sense_counter_status tsc_touch_sense_counter_status_properties
    tsc_touch_sense_counter_status_properties_i (.*);

//--- sim/tsc_touch_sense_counter_status_tb.sv
// Purpose: register-level tests of the touch sense counter status block
// Assumes: bus tasks are entered just after a rising edge
// Notes:   the full high-byte wrap takes about 65k cycles

`timescale 1ns/100ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module tsc_touch_sense_counter_status_tb
    import tsc_pkg::*;
;
    localparam logic [11:0] A_LOW  = {IDX_COUNT_LOW, 2'b00};
    localparam logic [11:0] A_HIGH = {IDX_COUNT_HIGH, 2'b00};
    localparam logic [11:0] A_STAT = {IDX_STATUS_MASK, 2'b00};
    localparam logic [11:0] A_TMR  = {IDX_TIMER, 2'b00};
    localparam logic [11:0] A_CTL  = {IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_BAD  = 12'h2a0;  // unmapped word

    logic mclk = 1'b0, rst = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] timer_value;
    logic sense_in, count_step, step_busy, sense_lvl = 1'b0, step_go = 1'b0, slow = 1'b0;
    logic [16:0] step_n = 17'h0;
    int error_cnt = 0, checks = 0, cyc = 0;

    always #5 mclk = ~mclk;

    tsc_touch_sense_counter_status tsc_touch_sense_counter_status_i (.*);
    tsc_sense_model tsc_sense_model_i (.*);

    // ****************************************************************
    // bus and stimulus tasks
    // ****************************************************************
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
        logic aw_d = 1'b0, w_d = 1'b0;
        @(posedge mclk);
        s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_bready <= 1'b1;
        s_axi_wvalid <= 1'b1; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
        // halves may be taken on different edges
        while (!(aw_d && w_d))
        begin
            @(posedge mclk);
            if (!aw_d && s_axi_awready === 1'b1) begin aw_d = 1'b1; s_axi_awvalid <= 1'b0; end
            if (!w_d && s_axi_wready === 1'b1) begin w_d = 1'b1; s_axi_wvalid <= 1'b0; end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er = RESP_OKAY);
        @(posedge mclk);
        s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        `CHK(s_axi_rdata, ex)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'b0;
    endtask

    // burst of count pulses; waits until the model is idle
    task automatic step(input logic [16:0] n, input logic sl);
        @(posedge mclk);
        step_go <= 1'b1; step_n <= n; slow <= sl;
        @(posedge mclk);
        step_go <= 1'b0;
        do @(posedge mclk); while (step_busy);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard, well above the long wrap test
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 90000) begin error_cnt++; give_verdict(); end
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial
    begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rd(A_LOW, 32'h0);
        rd(A_HIGH, 32'h0);
        rd(A_STAT, 32'h0);
        rd(A_TMR, 32'h0);
        rd(A_BAD, 32'h0, RESP_SLVERR);
        wr(A_BAD, 32'hff, RESP_SLVERR);
        wr(A_LOW, 32'h55);
        rd(A_LOW, 32'h0);
        wr(A_TMR, 32'hff);
        rd(A_TMR, 32'h7f);
        `CHK(timer_value, 7'h7f)
        $display("test reset and registers done");
        // measurement: stop on input edge, then extra pulses must not count
        wr(A_CTL, 32'h03);
        step(17'd300, 1'b0);
        sense_lvl <= 1'b1;
        repeat (8) @(posedge mclk);
        step(17'd5, 1'b1);
        rd(A_LOW, 32'h2c);
        rd(A_HIGH, 32'h01);
        rd(A_STAT, 32'hd0);
        rd(A_CTL, 32'h03);
        wr(A_CTL, 32'h00);
        rd(A_LOW, 32'h0);
        rd(A_HIGH, 32'h0);
        $display("test measurement done");
        // masks changed only while disabled, flags kept by writing ones
        wr(A_STAT, 32'hf4);
        rd(A_STAT, 32'hd4);
        `CHK(irq, 1'b1)
        wr(A_STAT, 32'h78);
        rd(A_STAT, 32'h58);
        `CHK(irq, 1'b0)
        wr(A_STAT, 32'h00);
        rd(A_STAT, 32'h00);
        $display("test masks done");
        // flipped input: falling pin is the rising event
        wr(A_CTL, 32'h08);
        repeat (8) @(posedge mclk);
        rd(A_STAT, 32'h00);
        sense_lvl <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(A_STAT, 32'h80);
        wr(A_STAT, 32'h02);
        $display("test polarity done");
        // full wrap of the high byte raises the masked high carry
        wr(A_CTL, 32'h01);
        `CHK(irq, 1'b0)
        step(17'h10000, 1'b0);
        `CHK(irq, 1'b1)
        $display("test high carry done");
        give_verdict();
    end
endmodule // tsc_touch_sense_counter_status_tb
